// ### ppfs_board_model.sv
// Board model: the level seen on every port pin, plus the external reset source.
// Assumes bit order B[7:0], C[6:0], D[7:0] from bit 0 upward on all vectors.
`timescale 1ns/1ps
`default_nettype none

module ppfs_board_model (
    input  wire logic        clk_i,
    input  wire logic [22:0] out_i,
    input  wire logic [22:0] oe_i,
    input  wire logic [22:0] pu_i,
    input  wire logic [22:0] ext_i,
    input  wire logic [22:0] ext_en_i,
    output logic [22:0]      pins_o
);
    logic flip_q     = 1'b0;
    logic hold_low_q = 1'b0;

    // ----------------------------------------------------------------
    // Wire resolution
    // ----------------------------------------------------------------
    // Floating pins without pull-up wander, so a stale value never reads back
    always @(posedge clk_i) begin
        flip_q <= ~flip_q;
    end

    // Device driver first, then board driver, then pull-up, else wander
    always_comb begin
        for (int i = 0; i < 23; i++) begin
            pins_o[i] = oe_i[i] ? out_i[i] : ext_en_i[i] ? ext_i[i] : pu_i[i] | flip_q;
        end
        if (hold_low_q) begin
            pins_o[14] = 1'b0;
        end
    end

    // Reset source keeps the pin low for whole cycles; callers pass at least the minimum
    task automatic pulse_reset(input int cycles);
        @(posedge clk_i);
        hold_low_q <= 1'b1;
        repeat (cycles) @(posedge clk_i);
        hold_low_q <= 1'b0;
    endtask
endmodule // ppfs_board_model

`default_nettype wire

// ### ppfs_consts.svh
// Offsets, field positions, reset values and timing counts of the port pin function select.
// Assumes a byte-addressed classic Wishbone slave with 32-bit data and a 40 MHz clock.
`ifndef PPFS_CONSTS_SVH
`define PPFS_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses; in-port registers as word indices; one aligned word each)
// ----------------------------------------------------------------
`define PPFS_PORT_STRIDE   8'h10
`define PPFS_REG_OUT       2'h0
`define PPFS_REG_DIR       2'h1
`define PPFS_REG_PULLUP    2'h2
`define PPFS_REG_PINS      2'h3
`define PPFS_ADR_CTRL      8'h30
`define PPFS_ADR_STATUS    8'h34

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PPFS_CTRL_ASYNC_BIT   0
`define PPFS_STAT_XTAL_BIT    0
`define PPFS_STAT_TOSC_BIT    1
`define PPFS_STAT_RSTPIN_BIT  2
`define PPFS_STAT_PINRST_BIT  3
`define PPFS_RST_BYTE         8'h00
`define PPFS_MASK_B           8'hFF
`define PPFS_MASK_C           8'h7F
`define PPFS_MASK_D           8'hFF
`define PPFS_OSC_IN_BIT       6
`define PPFS_OSC_OUT_BIT      7
`define PPFS_RSTPIN_BIT       6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PPFS_CLK_PERIOD_NS    25
`define PPFS_MIN_PULSE_NS     2500
`define PPFS_MIN_PULSE_CYC    ((`PPFS_MIN_PULSE_NS + `PPFS_CLK_PERIOD_NS - 1) / `PPFS_CLK_PERIOD_NS)

`endif

// ### ppfs_pkg.sv
// Types shared by the port pin function select modules.
// Assumes ppfs_consts.svh supplies the numbers; only types live here.
package ppfs_pkg;

    // ----------------------------------------------------------------
    // Port indices
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PPFS_PORT_B,
        PPFS_PORT_C,
        PPFS_PORT_D
    } ppfs_port_e;

    typedef logic [2:0][7:0] ppfs_bytes_t;

    // State of the main block
    typedef struct packed {
        ppfs_bytes_t out;
        ppfs_bytes_t dir;
        ppfs_bytes_t pu;
        ppfs_bytes_t sync1;
        ppfs_bytes_t sync2;
        logic        async_sel;
        logic        ack;
        logic [31:0] rdat;
    } ppfs_state_s;

    // State of the reset pin qualifier
    typedef struct packed {
        logic        sync1;
        logic        sync2;
        logic [15:0] cnt;
        logic        req;
    } ppfs_filt_s;

endpackage

// ### ppfs_reset_filter.sv
// Reset pin qualifier: immediate pin reset path plus a clocked minimum-pulse filter.
// Assumes the pin is asynchronous and the enable is a static fuse level.
`timescale 1ns/1ps
`default_nettype none
`include "ppfs_consts.svh"

module ppfs_reset_filter
    import ppfs_pkg::*;
#(
    parameter int MIN_CYC = `PPFS_MIN_PULSE_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic enable_i,
    input  wire logic pin_i,
    output logic      pin_reset_now_o,
    output logic      pin_reset_req_o
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (MIN_CYC < 1 || MIN_CYC > 65535) begin : g_bad_cyc
        $error("ppfs_reset_filter: MIN_CYC out of range");
    end

    ppfs_filt_s q, d;

    // Low pin acts at once, without any clock edge
    assign pin_reset_now_o = enable_i & ~pin_i;
    assign pin_reset_req_o = q.req;

    // Count synchronised low cycles; shorter glitches never reach the request
    always_comb begin
        d       = q;
        d.sync1 = pin_i;
        d.sync2 = q.sync1;
        if (enable_i && !q.sync2) begin
            if (q.cnt < 16'(MIN_CYC)) begin
                d.cnt = q.cnt + 16'h0001;
            end
            d.req = (q.cnt >= 16'(MIN_CYC - 1));
        end else begin
            d.cnt = 16'h0000;
            d.req = 1'b0;
        end
    end

    // Register the state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{sync1: 1'b1, sync2: 1'b1, cnt: 16'h0000, req: 1'b0};
        end else begin
            q <= d;
        end
    end

    property p_filter_req;
        @(posedge clk_i) disable iff (rst_i)
        (enable_i && !q.sync2 && q.cnt == 16'(MIN_CYC - 1)) |=> pin_reset_req_o;
    endproperty
    a_filter_req: assert property (p_filter_req) else $error("pin reset not requested");

endmodule // ppfs_reset_filter
`default_nettype wire

// ### ppfs_top.sv
// Port pin function select: GPIO control of ports B, C, D with oscillator and reset pin claims.
// Assumes a classic Wishbone master on clk_i and static fuse levels from the fuse block.
//
// Functional notes
// - All port pins float whenever any reset is active, even without a clock.
// - Each port bit has its own pull-up enable.
// - Port C is seven bits wide; ports B and D are eight bits.
// - Reset-disable fuse programmed: port C bit six is plain GPIO.
// - Fuse unprogrammed: port C bit six low long enough resets the device.
// - Crystal clock fuse routes port B bits six/seven to the oscillator amplifier.
// - RC clock with async select routes port B bits six/seven to timer oscillator.
//
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ppfs_consts.svh"

module ppfs_top
    import ppfs_pkg::*;
#(
    parameter int MIN_PULSE_CYC = `PPFS_MIN_PULSE_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        reset_pin_disable_fuse_i,
    input  wire logic        clk_src_xtal_fuse_i,
    input  wire logic        clk_src_rc_fuse_i,
    input  wire logic [7:0]  port_b_pins_i,
    output logic [7:0]       port_b_pins_o,
    output logic [7:0]       port_b_pins_oe_o,
    output logic [7:0]       port_b_pullup_o,
    input  wire logic [6:0]  port_c_pins_i,
    output logic [6:0]       port_c_pins_o,
    output logic [6:0]       port_c_pins_oe_o,
    output logic [6:0]       port_c_pullup_o,
    input  wire logic [7:0]  port_d_pins_i,
    output logic [7:0]       port_d_pins_o,
    output logic [7:0]       port_d_pins_oe_o,
    output logic [7:0]       port_d_pullup_o,
    output logic             crystal_in_o,
    input  wire logic        crystal_out_i,
    output logic             timer_osc_in_o,
    input  wire logic        timer_osc_out_i,
    output logic             chip_reset_o
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    ppfs_state_s q, d;
    ppfs_bytes_t mask;
    ppfs_bytes_t claim;
    ppfs_bytes_t raw_pins;
    ppfs_bytes_t gp_o, gp_oe, gp_pu;
    logic        pin_reset_now;
    logic        pin_reset_req;
    logic        any_reset;
    logic        xtal_active;
    logic        tosc_active;
    logic        rstpin_mode;
    logic        req;
    logic [1:0]  port_idx;
    logic [1:0]  reg_idx;

    // ----------------------------------------------------------------
    // Reset pin qualifier
    // ----------------------------------------------------------------
    ppfs_reset_filter #(
        .MIN_CYC (MIN_PULSE_CYC)
    ) u_rst_filter (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .enable_i        (rstpin_mode),
        .pin_i           (port_c_pins_i[`PPFS_RSTPIN_BIT]),
        .pin_reset_now_o (pin_reset_now),
        .pin_reset_req_o (pin_reset_req)
    );

    // Pin reset reaches the floats combinationally, so no clock is needed
    assign rstpin_mode  = ~reset_pin_disable_fuse_i;
    assign any_reset    = rst_i | pin_reset_now | pin_reset_req;
    assign chip_reset_o = any_reset;

    // ----------------------------------------------------------------
    // Special function claims
    // ----------------------------------------------------------------
    assign xtal_active = clk_src_xtal_fuse_i;
    assign tosc_active = clk_src_rc_fuse_i & ~clk_src_xtal_fuse_i & q.async_sel;
    assign mask        = {`PPFS_MASK_D, `PPFS_MASK_C, `PPFS_MASK_B};
    assign raw_pins    = {port_d_pins_i, 1'b0, port_c_pins_i, port_b_pins_i};

    // Claimed bits are masked out of GPIO control
    always_comb begin
        claim = '0;
        if (xtal_active || tosc_active) begin
            claim[PPFS_PORT_B][`PPFS_OSC_IN_BIT]  = 1'b1;
            claim[PPFS_PORT_B][`PPFS_OSC_OUT_BIT] = 1'b1;
        end
        if (rstpin_mode) begin
            claim[PPFS_PORT_C][`PPFS_RSTPIN_BIT] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Per-port GPIO drive and pull-up
    // ----------------------------------------------------------------
    for (genvar p = 0; p < 3; p++) begin : g_port
        assign gp_oe[p] = {8{~any_reset}} & ~claim[p] & mask[p] & q.dir[p];
        assign gp_o[p]  = gp_oe[p] & q.out[p];
        assign gp_pu[p] = {8{~any_reset}} & ~claim[p] & mask[p] & ~q.dir[p] & q.pu[p];
    end

    // Oscillator amplifier output drives bit seven while claimed, still floated in reset
    always_comb begin
        port_b_pins_o    = gp_o[PPFS_PORT_B];
        port_b_pins_oe_o = gp_oe[PPFS_PORT_B];
        if (!any_reset && xtal_active) begin
            port_b_pins_o[`PPFS_OSC_OUT_BIT]    = crystal_out_i;
            port_b_pins_oe_o[`PPFS_OSC_OUT_BIT] = 1'b1;
        end else if (!any_reset && tosc_active) begin
            port_b_pins_o[`PPFS_OSC_OUT_BIT]    = timer_osc_out_i;
            port_b_pins_oe_o[`PPFS_OSC_OUT_BIT] = 1'b1;
        end
    end

    // Oscillator inputs see the raw pin; the amplifier needs no synchroniser
    assign crystal_in_o     = xtal_active & port_b_pins_i[`PPFS_OSC_IN_BIT];
    assign timer_osc_in_o   = tosc_active & port_b_pins_i[`PPFS_OSC_IN_BIT];
    assign port_b_pullup_o  = gp_pu[PPFS_PORT_B];
    assign port_c_pins_o    = gp_o[PPFS_PORT_C][6:0];
    assign port_c_pins_oe_o = gp_oe[PPFS_PORT_C][6:0];
    assign port_c_pullup_o  = gp_pu[PPFS_PORT_C][6:0];
    assign port_d_pins_o    = gp_o[PPFS_PORT_D];
    assign port_d_pins_oe_o = gp_oe[PPFS_PORT_D];
    assign port_d_pullup_o  = gp_pu[PPFS_PORT_D];

    // ----------------------------------------------------------------
    // Wishbone slave and pin synchronisers
    // ----------------------------------------------------------------
    assign req      = wb_cyc_i & wb_stb_i & ~q.ack;
    assign port_idx = wb_adr_i[5:4];
    assign reg_idx  = wb_adr_i[3:2];
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;

    // One wait state: ack follows the request by one edge and drops after one cycle
    always_comb begin
        d       = q;
        d.sync1 = raw_pins;
        d.sync2 = q.sync1;
        d.ack   = req;
        d.rdat  = 32'h0000_0000;
        if (req) begin
            if (wb_adr_i[7:6] == 2'h0 && port_idx != 2'h3 && wb_adr_i[1:0] == 2'h0) begin
                if (reg_idx == `PPFS_REG_OUT) begin
                    d.rdat[7:0] = q.out[port_idx];
                    if (wb_we_i && wb_sel_i[0]) d.out[port_idx] = wb_dat_i[7:0] & mask[port_idx];
                end else if (reg_idx == `PPFS_REG_DIR) begin
                    d.rdat[7:0] = q.dir[port_idx];
                    if (wb_we_i && wb_sel_i[0]) d.dir[port_idx] = wb_dat_i[7:0] & mask[port_idx];
                end else if (reg_idx == `PPFS_REG_PULLUP) begin
                    d.rdat[7:0] = q.pu[port_idx];
                    if (wb_we_i && wb_sel_i[0]) d.pu[port_idx] = wb_dat_i[7:0] & mask[port_idx];
                end else begin
                    d.rdat[7:0] = q.sync2[port_idx] & mask[port_idx];
                end
            end else if (wb_adr_i == `PPFS_ADR_CTRL) begin
                d.rdat[`PPFS_CTRL_ASYNC_BIT] = q.async_sel;
                if (wb_we_i && wb_sel_i[0]) d.async_sel = wb_dat_i[`PPFS_CTRL_ASYNC_BIT];
            end else if (wb_adr_i == `PPFS_ADR_STATUS) begin
                d.rdat[`PPFS_STAT_XTAL_BIT]   = xtal_active;
                d.rdat[`PPFS_STAT_TOSC_BIT]   = tosc_active;
                d.rdat[`PPFS_STAT_RSTPIN_BIT] = rstpin_mode;
                d.rdat[`PPFS_STAT_PINRST_BIT] = pin_reset_req;
            end
        end
    end

    // Register the state; a qualified pin reset clears settings like rst_i
    always_ff @(posedge clk_i) begin
        if (rst_i || pin_reset_req) begin
            q           <= '0;
            q.out       <= {3{`PPFS_RST_BYTE}};
            q.dir       <= {3{`PPFS_RST_BYTE}};
            q.pu        <= {3{`PPFS_RST_BYTE}};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_reset_float;
        @(posedge clk_i)
        any_reset |-> (port_b_pins_oe_o == 8'h00 && port_c_pins_oe_o == 7'h00
                       && port_d_pins_oe_o == 8'h00 && port_d_pullup_o == 8'h00);
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("pins driven in reset");

    property p_pullup_write;
        @(posedge clk_i) disable iff (any_reset)
        (req && wb_we_i && wb_sel_i[0] && wb_adr_i == (`PPFS_PORT_STRIDE * 2 + 8'h08)
         && q.dir[PPFS_PORT_D] == 8'h00) |=> ##1 (port_d_pullup_o == $past(wb_dat_i[7:0], 2));
    endproperty
    a_pullup_write: assert property (p_pullup_write) else $error("pull-up not applied");

    property p_port_c_width;
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && wb_adr_i[7:4] == 4'h1) |=> (wb_ack_o && wb_dat_o[31:7] == 25'h0);
    endproperty
    a_port_c_width: assert property (p_port_c_width) else $error("port C wider than 7");

    property p_gpio_c6;
        @(posedge clk_i) disable iff (any_reset)
        reset_pin_disable_fuse_i |-> (port_c_pins_oe_o[6] == q.dir[PPFS_PORT_C][6]);
    endproperty
    a_gpio_c6: assert property (p_gpio_c6) else $error("C6 not GPIO");

    property p_pin_reset;
        @(posedge clk_i)
        (!reset_pin_disable_fuse_i && !port_c_pins_i[6]) |-> (chip_reset_o && port_c_pins_oe_o == 7'h00);
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset ignored");

    property p_xtal_route;
        @(posedge clk_i) disable iff (any_reset)
        xtal_active |-> (port_b_pins_oe_o[7] && port_b_pins_o[7] == crystal_out_i
                         && crystal_in_o == port_b_pins_i[6] && !port_b_pullup_o[6]);
    endproperty
    a_xtal_route: assert property (p_xtal_route) else $error("crystal not routed");

    sequence s_async_set;
        req && wb_we_i && wb_sel_i[0] && wb_adr_i == `PPFS_ADR_CTRL && wb_dat_i[0];
    endsequence
    property p_tosc_route;
        @(posedge clk_i) disable iff (any_reset)
        (s_async_set and (clk_src_rc_fuse_i && !clk_src_xtal_fuse_i)) |=> ##1
        (timer_osc_in_o == port_b_pins_i[6] && port_b_pins_o[7] == timer_osc_out_i);
    endproperty
    a_tosc_route: assert property (p_tosc_route) else $error("timer osc not routed");

    property p_claim_ignores;
        @(posedge clk_i) disable iff (rst_i)
        rstpin_mode |-> (!port_c_pullup_o[6] && !port_c_pins_oe_o[6]);
    endproperty
    a_claim_ignores: assert property (p_claim_ignores) else $error("claimed pin used");

endmodule // ppfs_top
`default_nettype wire

// ### ppfs_top_tb.sv
// Self-checking bench for the port pin function select.
// Assumes the board model resolves the pins and MIN_PULSE_CYC is shortened to 4.
`timescale 1ns/1ps
`default_nettype none

module ppfs_top_tb;
    import ppfs_pkg::*;
    localparam int MINP = 4;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        dis = 1'b1;
    logic        xtal = 1'b0;
    logic        rc = 1'b0;
    logic        xout = 1'b0;
    logic        tout = 1'b0;
    logic [22:0] ext = 23'h7FFFFF;
    logic [22:0] pins;
    logic [7:0]  b_o, b_oe, b_pu, d_o, d_oe, d_pu;
    logic [6:0]  c_o, c_oe, c_pu;
    logic        xin, tin, chip_rst;
    int          bad_count = 0;
    int          comparisons = 0;
    int          cycles = 0;

    ppfs_top #(.MIN_PULSE_CYC(MINP)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .reset_pin_disable_fuse_i(dis), .clk_src_xtal_fuse_i(xtal), .clk_src_rc_fuse_i(rc),
        .port_b_pins_i(pins[7:0]), .port_b_pins_o(b_o), .port_b_pins_oe_o(b_oe),
        .port_b_pullup_o(b_pu), .port_c_pins_i(pins[14:8]), .port_c_pins_o(c_o),
        .port_c_pins_oe_o(c_oe), .port_c_pullup_o(c_pu), .port_d_pins_i(pins[22:15]),
        .port_d_pins_o(d_o), .port_d_pins_oe_o(d_oe), .port_d_pullup_o(d_pu),
        .crystal_in_o(xin), .crystal_out_i(xout), .timer_osc_in_o(tin),
        .timer_osc_out_i(tout), .chip_reset_o(chip_rst));
    ppfs_board_model brd (.clk_i(clk_i), .out_i({d_o, c_o, b_o}), .oe_i({d_oe, c_oe, b_oe}),
        .pu_i({d_pu, c_pu, b_pu}), .ext_i(ext), .ext_en_i(23'h7FFFFF), .pins_o(pins));

    // ----------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------------------------------
    always #12.5 clk_i = ~clk_i;

    // A hang counts as a mismatch and ends the run
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    // Classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [31:0] r;
        wb(1'b1, adr, {24'h0, d}, r);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, adr, 32'h0, r);
        check(what, exp, r);
    endtask

    // Fuses only change while reset is held
    task automatic do_reset(input logic f_dis, input logic f_xtal, input logic f_rc);
        rst_i <= 1'b1;
        dis   <= f_dis;
        xtal  <= f_xtal;
        rc    <= f_rc;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        for (int p = 0; p < 3; p++) begin
            rd_chk("dir_rst", 8'(p * 16 + 4), 32'h0);
            wr(8'(p * 16), 8'hFF);
            rd_chk("out_width", 8'(p * 16), (p == 1) ? 32'h7F : 32'hFF);
        end
        wb_sel_i <= 4'h0;
        wr(8'h08, 8'h33);
        wb_sel_i <= 4'hF;
        rd_chk("sel_off", 8'h08, 32'h0);
        rd_chk("unmapped", 8'h38, 32'h0);
        // Misaligned address over a register that holds FF must still read zero
        rd_chk("misalign", 8'h01, 32'h0);
    endtask

    task automatic t_drive();
        wr(8'h04, 8'h0F);
        wr(8'h00, 8'h55);
        wr(8'h08, 8'hFF);
        check("b_oe", 32'h0F, {24'h0, b_oe});
        check("b_out", 32'h05, {24'h0, b_o & b_oe});
        check("b_pu", 32'hF0, {24'h0, b_pu});
        wr(8'h28, 8'h81);
        check("d_pu", 32'h81, {24'h0, d_pu});
        wr(8'h14, 8'h7F);
        wr(8'h10, 8'h2A);
        check("c_oe", 32'h7F, {25'h0, c_oe});
        ext[22:15] <= 8'h3C;
        repeat (3) @(posedge clk_i);
        rd_chk("d_pins", 8'h2C, 32'h3C);
        rd_chk("c_pins", 8'h1C, 32'h2A);
        // Port D outputs on the high nibble; pull-ups survive only on input bits
        wr(8'h24, 8'hF0);
        check("d_oe", 32'hF0, {24'h0, d_oe});
        check("d_out", 32'hF0, {24'h0, d_o});
        check("d_pu_dir", 32'h01, {24'h0, d_pu});
    endtask

    task automatic t_reset_float();
        rst_i <= 1'b1;
        #1;
        check("oe_in_rst", 32'h0, {9'h0, d_oe, c_oe, b_oe});
        check("pu_in_rst", 32'h0, {9'h0, d_pu, c_pu, b_pu});
        // Back onto the edge before the fuses move
        @(posedge clk_i);
        do_reset(1'b0, 1'b0, 1'b0);
        rd_chk("dir_after", 8'h14, 32'h0);
    endtask

    task automatic t_pin_reset();
        wr(8'h14, 8'h7F);
        check("c6_claim", 32'h3F, {25'h0, c_oe});
        rd_chk("stat_rst", 8'h34, 32'h4);
        ext[14] <= 1'b0;
        #1;
        check("pin_rst_now", 32'h1, {31'h0, chip_rst});
        check("pin_rst_oe", 32'h0, {25'h0, c_oe});
        @(posedge clk_i);
        ext[14] <= 1'b1;
        // A one-cycle glitch is below the filter length and keeps the settings
        rd_chk("glitch_kept", 8'h14, 32'h7F);
        do_reset(1'b0, 1'b0, 1'b0);
        wr(8'h14, 8'h7F);
        brd.pulse_reset(MINP + 3);
        repeat (4) @(posedge clk_i);
        check("rst_released", 32'h0, {31'h0, chip_rst});
        rd_chk("dir_cleared", 8'h14, 32'h0);
    endtask

    task automatic t_xtal();
        do_reset(1'b1, 1'b1, 1'b0);
        wr(8'h04, 8'hFF);
        wr(8'h00, 8'hFF);
        xout  <= 1'b1;
        ext[6] <= 1'b0;
        #1;
        check("xin_lo", 32'h0, {31'h0, xin});
        check("b_oe_x", 32'hBF, {24'h0, b_oe});
        check("xout_hi", 32'h1, {31'h0, b_o[7]});
        @(posedge clk_i);
        xout  <= 1'b0;
        ext[6] <= 1'b1;
        #1;
        check("xin_hi", 32'h1, {31'h0, xin});
        check("xout_lo", 32'h0, {31'h0, b_o[7]});
        @(posedge clk_i);
        rd_chk("stat_x", 8'h34, 32'h1);
    endtask

    task automatic t_tosc();
        do_reset(1'b1, 1'b0, 1'b1);
        wr(8'h04, 8'h80);
        check("tin_off", 32'h0, {31'h0, tin});
        check("b7_gpio", 32'h80, {24'h0, b_oe});
        wr(8'h30, 8'h01);
        tout  <= 1'b1;
        ext[6] <= 1'b1;
        #1;
        check("tin_hi", 32'h1, {31'h0, tin});
        check("tout_hi", 32'h1, {31'h0, b_o[7]});
        @(posedge clk_i);
        ext[6] <= 1'b0;
        #1;
        check("tin_lo", 32'h0, {31'h0, tin});
        @(posedge clk_i);
        rd_chk("stat_t", 8'h34, 32'h2);
    endtask

    // ----------------------------------------------------------------
    // Main sequence and verdict
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        do_reset(1'b1, 1'b0, 1'b0);
        t_regs();
        t_drive();
        t_reset_float();
        t_pin_reset();
        t_xtal();
        t_tosc();
        summarize();
    end
endmodule // ppfs_top_tb

`default_nettype wire
